// ===== uhm_asserts.sv
// Purpose: Concurrent checks on the command bus and side outputs.
// Assumes: One clock; reset synchronous and active low.
// Notes:   Watches signals only and never drives them.
`timescale 1ns/1ns
`default_nettype none
module uhm_asserts (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        req,
  input wire logic [7:0]  code,
  input wire logic [31:0] wdata,
  input wire logic        rd_valid,
  input wire logic        frame_end_i,
  input wire logic        periodic_done_i,
  input wire logic        overrun_flag_set_o,
  input wire logic        hub_reset_o,
  input wire logic        soft_reset_o,
  input wire logic        sof_run_o,
  input wire logic        frame_start_flag_set_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////////
  // Requests that must draw an answer, start a reset or stop frame starts.
  sequence rd_req_s;
    req && (code == uhm_pkg::UHM_RD_MODE || code == uhm_pkg::UHM_RD_CMDST);
  endsequence
  sequence srst_req_s;
    req && code == uhm_pkg::UHM_WR_CMDST && wdata[uhm_pkg::UHM_RST_BIT];
  endsequence
  sequence leave_oper_s;
    req && code == uhm_pkg::UHM_WR_MODE &&
      wdata[uhm_pkg::UHM_FS_HI:uhm_pkg::UHM_FS_LO] != uhm_pkg::UHM_FS_OPER;
  endsequence
  rd_answer_a: assert property (rd_req_s |=> rd_valid)
    else $error("read strobe got no answer");
  rd_cause_a: assert property (rd_valid |-> $past(req) &&
    ($past(code) == uhm_pkg::UHM_RD_MODE ||
     $past(code) == uhm_pkg::UHM_RD_CMDST))
    else $error("read answer without a read strobe");
  srst_go_a: assert property (srst_req_s |->
    ##[1:2] soft_reset_o)
    else $error("reset command did not start");
  srst_end_a: assert property ($rose(soft_reset_o) |->
    ##[1:8] !soft_reset_o)
    else $error("software reset never finished");
  hub_keep_a: assert property (soft_reset_o |-> !hub_reset_o)
    else $error("software reset touched the hub");
  hub_hw_a: assert property ($rose(rst_b_i) |=>
    hub_reset_o ##1 !hub_reset_o)
    else $error("hub reset not held one edge past hardware reset");
  ovr_set_a: assert property (frame_end_i && !periodic_done_i |=>
    overrun_flag_set_o)
    else $error("overrun not flagged");
  ovr_cause_a: assert property (overrun_flag_set_o |->
    $past(frame_end_i) && !$past(periodic_done_i))
    else $error("overrun flagged without a missed frame");
  sof_flag_a: assert property ($rose(sof_run_o) |->
    frame_start_flag_set_o)
    else $error("frame start without its flag");
  sof_stop_a: assert property (leave_oper_s |=> !sof_run_o)
    else $error("frame starts kept running");
endmodule
`default_nettype wire

// ===== uhm_bus_if.sv
// Purpose: Command-code parallel bus between driver and register pair.
// Assumes: Single clock; one request per strobe.
// Notes:   Read data returns with rd_valid one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
interface uhm_bus_if;
  logic        req;
  logic [7:0]  code;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        rd_valid;
  modport dev (input req, code, wdata, output rdata, rd_valid);
  modport drv (output req, code, wdata, input rdata, rd_valid);
endinterface
`default_nettype wire

// ===== uhm_delay_cnt.sv
// Purpose: One-shot down counter that pulses when a delay has run out.
// Assumes: Restart wins over a running count.
// Notes:   Used for the frame start delay.
`timescale 1ns/1ns
`default_nettype none
module uhm_delay_cnt #(
  parameter int CYCLES = uhm_pkg::UHM_SOF_CYC
) (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic start_i,
  input  wire logic abort_i,
  output logic      done_o
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);
  localparam logic [W-1:0] ONE  = W'(1);
  logic [W-1:0] cnt_q;
  logic         run_q;
  wire          last = run_q && (cnt_q == ONE);

  // Count down while running; done pulses on the final cycle.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || abort_i) begin
      run_q  <= 1'b0;
      cnt_q  <= '0;
      done_o <= 1'b0;
    end else if (start_i) begin
      run_q  <= 1'b1;
      cnt_q  <= LOAD;
      done_o <= 1'b0;
    end else begin
      done_o <= last;
      if (last) begin
        run_q <= 1'b0;
      end
      if (run_q) begin
        cnt_q <= cnt_q - ONE;
      end
    end
  end
endmodule
`default_nettype wire

// ===== uhm_dev.sv
// Purpose: Operating-mode and command/status registers of the controller.
// Assumes: Bus strobes are synchronous; events are one-cycle pulses.
// Notes:   Reads have no side effects; command bits are write-to-set.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Enable plus resume seen signals remote wake
// - Wake enable never gates any interrupt
// - Hardware reset clears connected, software keeps
// - Firmware sets connected bit during self test
// - Only driver changes the wake enable
// - State codes; frame start 1 ms after operational
// - Hardware changes state only from suspend
// - Suspend moves to resume on port resume
// - Any reset puts state into reset
// - Hardware reset alone resets hub and ports
// - Command writes set ones, keep zeros
// - Command reads return bits without side effects
// - Overrun when periodic list misses frame end
// - Each overrun bumps counter and flags status
// - Mode register read 01, written 81
// - Command register read 02, written 82
// - Two-bit counter at 17:16 wraps freely
// - Driver keeps reserved bits, writes zero sets
module uhm_dev #(
  parameter int SOF_CYCLES = uhm_pkg::UHM_SOF_CYC
) (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  uhm_bus_if.dev    bus,
  input  wire logic port_resume_i,
  input  wire logic frame_end_i,
  input  wire logic periodic_done_i,
  input  wire logic resume_seen_i,
  output logic      remote_wake_o,
  output logic      sof_run_o,
  output logic      overrun_flag_set_o,
  output logic      hub_reset_o,
  output logic      soft_reset_o,
  output logic      frame_start_flag_set_o
);
  ////////////////////////////////////////////////////////////////////////
  // Register state.
  logic        rwe_q;
  logic        rwc_q;
  logic [1:0]  fs_q;
  logic [1:0]  fs_d;
  logic [1:0]  ovc_q;
  logic        hcr_q;
  logic [2:0]  srst_cnt_q;
  logic        hard_rst_q;

  ////////////////////////////////////////////////////////////////////////
  // Decode of command codes.
  // A strobe with an unknown code matches nothing and is dropped, so the
  // driver can never disturb a register that it did not name.
  function automatic logic code_hit(input logic       req,
                                    input logic [7:0] code,
                                    input logic [7:0] want);
    return req && (code == want);
  endfunction
  // Each register has its own read code and its own write code.
  wire wr_mode  = code_hit(bus.req, bus.code,
                           uhm_pkg::UHM_WR_MODE);
  wire rd_mode  = code_hit(bus.req, bus.code,
                           uhm_pkg::UHM_RD_MODE);
  wire wr_cmdst = code_hit(bus.req, bus.code,
                           uhm_pkg::UHM_WR_CMDST);
  wire rd_cmdst = code_hit(bus.req, bus.code,
                           uhm_pkg::UHM_RD_CMDST);
  // A one written to the reset bit starts a software reset.
  wire sw_rst_go  = wr_cmdst && bus.wdata[uhm_pkg::UHM_RST_BIT];
  wire sw_rst_end = hcr_q &&
                    (srst_cnt_q == 3'(uhm_pkg::UHM_SRST_CYC));
  // Overrun: frame ended with the periodic list still running.
  wire overrun    = frame_end_i && !periodic_done_i;
  wire [1:0] wr_fs = bus.wdata[uhm_pkg::UHM_FS_HI:uhm_pkg::UHM_FS_LO];
  wire enter_oper = (fs_d == uhm_pkg::UHM_FS_OPER) &&
                    (fs_q != uhm_pkg::UHM_FS_OPER);
  wire leave_oper = (fs_d != uhm_pkg::UHM_FS_OPER);
  logic sof_done;

  // Read data images; reserved bits read as zero.
  // Reserved positions are tied low here, yet the driver must still keep
  // them on its own writes, since later versions may give them a meaning.
  logic [31:0] mode_img;
  logic [31:0] cmdst_img;
  always_comb begin
    mode_img = uhm_pkg::UHM_ZERO32;
    mode_img[uhm_pkg::UHM_RWE_BIT] = rwe_q;
    mode_img[uhm_pkg::UHM_RWC_BIT] = rwc_q;
    mode_img[uhm_pkg::UHM_FS_HI:uhm_pkg::UHM_FS_LO] = fs_q;
    cmdst_img = uhm_pkg::UHM_ZERO32;
    cmdst_img[uhm_pkg::UHM_OVC_HI:uhm_pkg::UHM_OVC_LO] = ovc_q;
    cmdst_img[uhm_pkg::UHM_RST_BIT] = hcr_q;
  end

  // Next functional state: resets first, then software, then hardware.
  // Software write wins over a same-cycle resume so the driver is obeyed.
  // Hardware moves the state only out of suspend; every other change
  // comes from a write or from a reset.
  always_comb begin
    fs_d = fs_q;
    if (sw_rst_go || sw_rst_end) begin
      fs_d = uhm_pkg::UHM_FS_RESET;
    end else if (wr_mode) begin
      fs_d = wr_fs;
    end else if (fs_q == uhm_pkg::UHM_FS_SUSP && port_resume_i) begin
      fs_d = uhm_pkg::UHM_FS_RESUME;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operating-mode register.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rwe_q <= 1'b0;
      rwc_q <= 1'b0;
      fs_q  <= uhm_pkg::UHM_FS_RESET;
    end else begin
      fs_q <= fs_d;
      if (wr_mode) begin
        rwe_q <= bus.wdata[uhm_pkg::UHM_RWE_BIT];
        rwc_q <= bus.wdata[uhm_pkg::UHM_RWC_BIT];
      end
      if (sw_rst_go) begin
        rwe_q <= 1'b0;   // Connected bit survives software reset.
      end
    end
  end

  // Command register: reset bit set by write, cleared when reset is done.
  // The reset lasts a fixed handful of cycles, far inside the time the
  // driver must wait, and the bit reads back as one until it is over.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      hcr_q      <= 1'b0;
      srst_cnt_q <= '0;
      ovc_q      <= uhm_pkg::UHM_OVC_INIT;
    end else begin
      if (sw_rst_go) begin
        hcr_q      <= 1'b1;
        srst_cnt_q <= '0;
      end else if (sw_rst_end) begin
        hcr_q <= 1'b0;
      end else if (hcr_q) begin
        srst_cnt_q <= srst_cnt_q + 3'h1;
      end
      if (overrun) begin
        ovc_q <= ovc_q + uhm_pkg::UHM_OVC_ONE;
      end
    end
  end

  // Read port: a registered copy, so reads never disturb state.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      bus.rdata    <= uhm_pkg::UHM_ZERO32;
      bus.rd_valid <= 1'b0;
    end else begin
      bus.rd_valid <= rd_mode || rd_cmdst;
      bus.rdata    <= rd_mode  ? mode_img :
                      rd_cmdst ? cmdst_img : uhm_pkg::UHM_ZERO32;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame start delay after entering operational.
  // Any change that leaves operational aborts the count, so a quick leave
  // and re-enter always waits the full delay again.
  uhm_delay_cnt #(
    .CYCLES(SOF_CYCLES)
  ) u_sof_dly (
    .mclk_i (mclk_i),
    .rst_b_i(rst_b_i),
    .start_i(enter_oper),
    .abort_i(leave_oper),
    .done_o (sof_done)
  );

  // Outputs, all registered. Wake ignores any interrupt enable.
  // Wake is a plain AND of the enable and the resume flag; it has no path
  // into interrupt logic, so the enable can never gate an interrupt.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      remote_wake_o          <= 1'b0;
      sof_run_o              <= 1'b0;
      overrun_flag_set_o     <= 1'b0;
      hard_rst_q             <= 1'b1;
      hub_reset_o            <= 1'b1;
      soft_reset_o           <= 1'b0;
      frame_start_flag_set_o <= 1'b0;
    end else begin
      remote_wake_o      <= rwe_q && resume_seen_i;
      overrun_flag_set_o <= overrun;
      if (leave_oper) begin
        sof_run_o <= 1'b0;
      end else if (sof_done) begin
        sof_run_o <= 1'b1;
      end
      frame_start_flag_set_o <= sof_done && !leave_oper;
      // The hub and its ports stay in reset one edge past a hardware
      // reset, so that even a one-cycle reset pulse still reaches them.
      hard_rst_q   <= 1'b0;
      hub_reset_o  <= hard_rst_q;  // Software reset never drives it.
      soft_reset_o <= hcr_q;
    end
  end
endmodule
`default_nettype wire

// ===== uhm_drv.sv
// Purpose: Driver end: turns user read/write requests into bus codes.
// Assumes: User holds one request until done_o.
// Notes:   Keeps reserved bits by presenting user data unchanged.
`timescale 1ns/1ns
`default_nettype none
module uhm_drv (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  uhm_bus_if.drv           bus,
  input  wire logic        go_i,
  input  wire logic        write_i,
  input  wire logic        sel_cmd_i,
  input  wire logic [31:0] wdata_i,
  output logic             done_o,
  output logic [31:0]      rdata_o
);
  typedef enum logic [1:0] {UHM_D_IDLE, UHM_D_WAIT} uhm_dst_t;
  uhm_dst_t st_q;
  // Codes picked per register and direction.
  wire [7:0] code_sel = sel_cmd_i ?
    (write_i ? uhm_pkg::UHM_WR_CMDST : uhm_pkg::UHM_RD_CMDST) :
    (write_i ? uhm_pkg::UHM_WR_MODE  : uhm_pkg::UHM_RD_MODE);

  // Issue one strobe, then wait for read data or finish writes at once.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_q      <= UHM_D_IDLE;
      bus.req   <= 1'b0;
      bus.code  <= 8'h00;
      bus.wdata <= uhm_pkg::UHM_ZERO32;
      done_o    <= 1'b0;
      rdata_o   <= uhm_pkg::UHM_ZERO32;
    end else begin
      bus.req <= 1'b0;
      done_o  <= 1'b0;
      unique case (st_q)
        UHM_D_IDLE: begin
          if (go_i && !done_o) begin
            bus.req   <= 1'b1;
            bus.code  <= code_sel;
            bus.wdata <= wdata_i;   // Caller supplies merged image.
            st_q      <= UHM_D_WAIT;
          end
        end
        UHM_D_WAIT: begin
          if (bus.code[uhm_pkg::UHM_WR_BIT] || bus.rd_valid) begin
            done_o  <= 1'b1;
            rdata_o <= bus.rd_valid ? bus.rdata : rdata_o;
            st_q    <= UHM_D_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== uhm_pkg.sv
// Purpose: Shared constants for the host-mode command register pair.
// Assumes: One 50 MHz clock; command codes travel on an 8-bit bus.
// Notes:   Both ends take their codes from here, the register end also its fields and timing; the interface sets its own widths.
package uhm_pkg;
  // Command codes: bit 7 set marks a write.
  localparam logic [7:0] UHM_RD_MODE   = 8'h01;
  localparam logic [7:0] UHM_WR_MODE   = 8'h81;
  localparam logic [7:0] UHM_RD_CMDST  = 8'h02;
  localparam logic [7:0] UHM_WR_CMDST  = 8'h82;
  localparam int         UHM_WR_BIT    = 7;
  // Field positions in the operating-mode register.
  localparam int         UHM_RWE_BIT   = 10;
  localparam int         UHM_RWC_BIT   = 9;
  localparam int         UHM_FS_HI     = 7;
  localparam int         UHM_FS_LO     = 6;
  // Field positions in the command and status register.
  localparam int         UHM_RST_BIT   = 0;
  localparam int         UHM_OVC_HI    = 17;
  localparam int         UHM_OVC_LO    = 16;
  localparam logic [31:0] UHM_ZERO32   = 32'h0000_0000;
  localparam logic [1:0]  UHM_OVC_INIT = 2'h0;
  localparam logic [1:0]  UHM_OVC_ONE  = 2'h1;
  // Functional state encodings.
  typedef enum logic [1:0] {
    UHM_FS_RESET  = 2'h0,
    UHM_FS_RESUME = 2'h1,
    UHM_FS_OPER   = 2'h2,
    UHM_FS_SUSP   = 2'h3
  } uhm_fs_t;
  // Timing: frame start delay after entering operational.
  localparam int UHM_CLK_MHZ    = 50;
  localparam int UHM_SOF_DLY_US = 1000;
  localparam int UHM_SOF_CYC    = UHM_SOF_DLY_US * UHM_CLK_MHZ;
  // Software reset completes well inside its 10 us budget.
  localparam int UHM_SRST_US    = 10;
  localparam int UHM_SRST_CYC   = 4;
endpackage

// ===== usb_host_mode_command_regs_tb_top.sv
// Purpose: Self-checking bench joining driver and register ends.
// Assumes: Inputs change on the falling edge only.
// Notes:   Frame start delay shortened to keep the run brief.
`timescale 1ns/1ns
`default_nettype none
module usb_host_mode_command_regs_tb_top;
  localparam int SOF = 20;
  logic        mclk_i, rst_b_i, go_i, write_i, sel_cmd_i, done_o;
  logic        port_resume_i, frame_end_i, periodic_done_i, resume_seen_i;
  logic        remote_wake_o, sof_run_o, overrun_flag_set_o, hub_reset_o;
  logic        soft_reset_o, frame_start_flag_set_o;
  logic [31:0] wdata_i, rdata_o, got, w, seed;
  int          fails = 0, checks = 0, cyc = 0, k, ovc;
  uhm_bus_if bus_if ();
  uhm_dev #(.SOF_CYCLES(SOF)) u_uhm_dev (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .bus(bus_if), .port_resume_i(port_resume_i), .frame_end_i(frame_end_i),
    .periodic_done_i(periodic_done_i), .resume_seen_i(resume_seen_i),
    .remote_wake_o(remote_wake_o), .sof_run_o(sof_run_o),
    .overrun_flag_set_o(overrun_flag_set_o), .hub_reset_o(hub_reset_o),
    .soft_reset_o(soft_reset_o),
    .frame_start_flag_set_o(frame_start_flag_set_o));
  uhm_drv u_uhm_drv (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus(bus_if),
    .go_i(go_i), .write_i(write_i), .sel_cmd_i(sel_cmd_i), .wdata_i(wdata_i),
    .done_o(done_o), .rdata_o(rdata_o));
  uhm_asserts u_uhm_asserts (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .req(bus_if.req), .code(bus_if.code), .wdata(bus_if.wdata),
    .rd_valid(bus_if.rd_valid), .frame_end_i(frame_end_i),
    .periodic_done_i(periodic_done_i),
    .overrun_flag_set_o(overrun_flag_set_o), .hub_reset_o(hub_reset_o),
    .soft_reset_o(soft_reset_o), .sof_run_o(sof_run_o),
    .frame_start_flag_set_o(frame_start_flag_set_o));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling so a hung handshake still ends the run.
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic close_out();
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // One user request, held until done; a spare cycle keeps requests apart.
  task automatic acc(input logic wr, sc, input logic [31:0] d);
    int n;
    n = 0;
    write_i = wr;
    sel_cmd_i = sc;
    wdata_i = d;
    go_i = 1'b1;
    do begin
      tick(1);
      n++;
    end while (done_o !== 1'b1 && n < 20);
    go_i = 1'b0;
    got = rdata_o;
    chk("done", 32'h1, {31'h0, done_o});
    tick(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; the bench model is the expected value in each compare.
  initial begin
    {rst_b_i, go_i, write_i, sel_cmd_i, port_resume_i} = '0;
    {frame_end_i, periodic_done_i, resume_seen_i} = '0;
    wdata_i = '0;
    seed = 32'h15ddab72;
    tick(2);
    rst_b_i = 1'b1;
    tick(1);
    acc(0, 0, 0);
    chk("mode reset", 32'h0, got);
    acc(0, 1, 0);
    chk("cmd reset", 32'h0, got);
    for (k = 0; k < 8; k++) begin
      seed = xs(seed);
      w = seed & 32'h0000_06c0;
      resume_seen_i = seed[31];
      acc(1, 0, w);
      acc(0, 0, 0);
      chk("mode rw", w, got);
      chk("wake", 32'(w[10] & seed[31]), 32'(remote_wake_o));
    end
    for (k = 0; k < 4; k++) begin
      w = 32'(k) << 6;
      acc(1, 0, w);
      port_resume_i = 1'b1;
      tick(1);
      port_resume_i = 1'b0;
      acc(0, 0, 0);
      chk("state", (k == 3) ? 32'h40 : w, got);
    end
    acc(1, 0, 32'h0);
    acc(1, 0, 32'h80);
    k = 0;
    while (sof_run_o !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    chk("sof delay", SOF, k);
    chk("sof flag", 32'h1, 32'(frame_start_flag_set_o));
    acc(1, 0, 32'h0);
    chk("sof stop", 32'h0, 32'(sof_run_o));
    for (k = 0; k < 6; k++) begin
      periodic_done_i = (k == 5);
      frame_end_i = 1'b1;
      tick(1);
      chk("ovr flag", 32'(k != 5), 32'(overrun_flag_set_o));
      frame_end_i = 1'b0;
      tick(1);
    end
    ovc = 5 % 4;
    acc(1, 1, 0);
    acc(0, 1, 0);
    chk("overruns", ovc << 16, got);
    acc(1, 0, 32'h680);
    acc(1, 1, 32'h1);
    chk("soft busy", 32'h1, 32'(soft_reset_o));
    tick(10);
    chk("soft done", 32'h0, 32'(soft_reset_o));
    acc(0, 0, 0);
    chk("soft mode", 32'h200, got);
    acc(0, 1, 0);
    chk("soft cmd", ovc << 16, got);
    acc(0, 1, 0);
    chk("cmd reread", ovc << 16, got);
    rst_b_i = 1'b0;
    tick(2);
    chk("hub", 32'h1, {31'h0, hub_reset_o});
    rst_b_i = 1'b1;
    tick(1);
    acc(0, 0, 0);
    chk("hard mode", 32'h0, got);
    acc(0, 1, 0);
    chk("hard cmd", 32'h0, got);
    close_out();
  end
endmodule
`default_nettype wire
